// File: src/pieb_map.svh
// Register offsets, field layouts and reset values of the enable bank.
`ifndef PIEB_MAP_SVH
`define PIEB_MAP_SVH

`define PIEB_NGRP       5
`define PIEB_NSRC       40
`define PIEB_ADDR_W     8
`define PIEB_DATA_W     8

`define PIEB_OFS_EN1    8'h97
`define PIEB_OFS_EN2    8'h98
`define PIEB_OFS_EN3    8'h99
`define PIEB_OFS_EN4    8'h9A
`define PIEB_OFS_EN5    8'h9B

`define PIEB_OFS_FLAG1  8'h8D
`define PIEB_OFS_FLAG2  8'h8E
`define PIEB_OFS_FLAG3  8'h8F
`define PIEB_OFS_FLAG4  8'h90
`define PIEB_OFS_FLAG5  8'h91

`define PIEB_OFS_CTRL   8'h0B
`define PIEB_BIT_GLOBAL 7
`define PIEB_BIT_PERIPH 6

// Implemented bits per group; group 2 lacks bits 7 and 4, group 3 bits 7..4.
`define PIEB_IMPL_G1    8'hFF
`define PIEB_IMPL_G2    8'h6F
`define PIEB_IMPL_G3    8'h0F
`define PIEB_IMPL_G4    8'hFF
`define PIEB_IMPL_G5    8'hFF

`define PIEB_RST_EN     8'h00
`define PIEB_RST_FLAG   8'h00
`define PIEB_RST_RDATA  8'h00
`define PIEB_ZERO_BYTE  8'h00
`define PIEB_RST_VEC    16'h0000
`define PIEB_VECTOR     16'h0004

`endif

// File: src/pieb_pkg.sv
// Types shared by the peripheral interrupt enable bank.
package pieb_pkg;

    typedef logic [7:0] pieb_byte_t;
    typedef logic [15:0] pieb_pc_t;

    typedef enum logic {
        VS_IDLE,
        VS_LOAD
    } pieb_vec_state_t;

endpackage : pieb_pkg

// File: src/pieb_bank.sv
// Peripheral interrupt enable bank with flags, masters and vector request.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps

`include "pieb_map.svh"

// What this block does
// - Group 1 enable register lives at 0x97, eight read/write bits reset to 0.
// - Group 1 gates t1 gate, t1, osc fail, clk switch, tuning, scan, crc, nvm.
// - Group 2 enable at 0x98 lacks bits 7 and 4, others read/write reset 0.
// - Group 2 bits 6,5,3..0 gate ccp2, ccp1, timer4, timer2, t3 gate, t3.
// - Group 3 enable at 0x99 keeps bits 3..0 read/write reset 0, 7..4 absent.
// - Group 3 bits 3..0 gate pwm2 param, pwm2 period, pwm1 param, pwm1 period.
// - Group 4 enable register lives at 0x9A, eight read/write bits reset to 0.
// - Group 4 gates serial1 rx and tx, cells 4..1, wavegen and synthesizer.
// - Group 5 enable register lives at 0x9B, eight read/write bits reset to 0.
// - Group 5 gates cmp2, cmp1, sync port collisions and events, serial2.
// - A clear enable bit blocks its source and a set bit lets it through.
// - Enabled sources reach the core only with both master enables set.
// - A source flag sets on its event whatever the enable bits hold.
// - Taking an interrupt loads vector 0004h and clears global enable.
module pieb_bank
    import pieb_pkg::*;
(
    input  wire logic                    core_clk,
    input  wire logic                    rstn,
    input  wire logic [`PIEB_ADDR_W-1:0] reg_addr,
    input  wire logic [`PIEB_DATA_W-1:0] reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [`PIEB_DATA_W-1:0] reg_rdata,
    input  wire logic [`PIEB_NSRC-1:0]   src_event,
    input  wire logic                    irq_take,
    input  wire logic                    irq_return,
    output logic                         periph_irq_req,
    output logic                         irq,
    output logic                         vector_load,
    output logic      [15:0]             vector_addr
);

    localparam pieb_byte_t EN_OFS [`PIEB_NGRP] = '{
        `PIEB_OFS_EN1, `PIEB_OFS_EN2, `PIEB_OFS_EN3,
        `PIEB_OFS_EN4, `PIEB_OFS_EN5
    };
    localparam pieb_byte_t FLAG_OFS [`PIEB_NGRP] = '{
        `PIEB_OFS_FLAG1, `PIEB_OFS_FLAG2, `PIEB_OFS_FLAG3,
        `PIEB_OFS_FLAG4, `PIEB_OFS_FLAG5
    };
    localparam pieb_byte_t IMPL [`PIEB_NGRP] = '{
        `PIEB_IMPL_G1, `PIEB_IMPL_G2, `PIEB_IMPL_G3,
        `PIEB_IMPL_G4, `PIEB_IMPL_G5
    };

    // Reset release is synchronised so every flop leaves reset together.
    logic                    rst_meta_n;
    logic                    rst_sync_n;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    pieb_byte_t              en_q    [`PIEB_NGRP];
    pieb_byte_t              flag_q  [`PIEB_NGRP];
    logic [`PIEB_NSRC-1:0]   en_flat;
    logic [`PIEB_NSRC-1:0]   flag_flat;
    logic [`PIEB_NSRC-1:0]   impl_flat;
    logic [`PIEB_NGRP-1:0]   en_sel;
    logic [`PIEB_NGRP-1:0]   flag_sel;
    pieb_byte_t              en_rd   [`PIEB_NGRP];
    pieb_byte_t              flag_rd [`PIEB_NGRP];

    logic                    global_en;
    logic                    periph_en;
    logic                    ctrl_sel;
    logic                    take_ok;
    pieb_vec_state_t         vec_state;
    pieb_vec_state_t         next_vec_state;
    pieb_byte_t              next_rdata;
    pieb_byte_t              ctrl_rd;
    pieb_byte_t              rd_or;

    // One slice per group: decode, enable storage and sticky flags.
    genvar g;
    generate
        for (g = 0; g < `PIEB_NGRP; g++) begin : g_grp
            wire en_hit   = (reg_addr == EN_OFS[g]);
            wire flag_hit = (reg_addr == FLAG_OFS[g]);
            wire en_wr    = reg_wr && en_hit;
            wire flag_wr  = reg_wr && flag_hit;
            wire [7:0] ev = src_event[g*8 +: 8] & IMPL[g];
            wire [7:0] clr = flag_wr ? (reg_wdata & IMPL[g])
                                     : `PIEB_ZERO_BYTE;

            assign en_sel[g]   = en_hit;
            assign flag_sel[g] = flag_hit;
            assign en_rd[g]    = en_hit ? en_q[g] : `PIEB_ZERO_BYTE;
            assign flag_rd[g]  = flag_hit ? flag_q[g] : `PIEB_ZERO_BYTE;
            assign en_flat[g*8 +: 8]   = en_q[g];
            assign flag_flat[g*8 +: 8] = flag_q[g];
            assign impl_flat[g*8 +: 8] = IMPL[g];

            // Absent bits are masked on write so they always read as zero.
            always_ff @(posedge core_clk or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    en_q[g] <= `PIEB_RST_EN;
                end else if (en_wr) begin
                    en_q[g] <= reg_wdata & IMPL[g];
                end
            end

            // A new event beats a clear in the same cycle.
            always_ff @(posedge core_clk or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    flag_q[g] <= `PIEB_RST_FLAG;
                end else begin
                    flag_q[g] <= (flag_q[g] & ~clr) | ev;
                end
            end
        end
    endgenerate

    assign ctrl_sel = (reg_addr == `PIEB_OFS_CTRL);

    always_comb begin
        rd_or = `PIEB_ZERO_BYTE;
        for (int i = 0; i < `PIEB_NGRP; i++) begin
            rd_or = rd_or | en_rd[i] | flag_rd[i];
        end
    end

    always_comb begin
        ctrl_rd = `PIEB_ZERO_BYTE;
        ctrl_rd[`PIEB_BIT_GLOBAL] = global_en;
        ctrl_rd[`PIEB_BIT_PERIPH] = periph_en;
    end

    assign next_rdata = !reg_rd ? `PIEB_ZERO_BYTE :
                        ctrl_sel ? ctrl_rd : rd_or;

    // Read data stand for exactly one cycle; unmapped reads return zero.
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_rdata <= `PIEB_RST_RDATA;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // The per-source gating is a plain AND so a cleared enable blocks at once.
    assign periph_irq_req = |(flag_flat & en_flat);
    assign irq = periph_irq_req && periph_en && global_en;

    // The core only vectors while it sees the request and global enable.
    assign take_ok = irq_take && irq;

    // Hardware clear on vectoring wins over a software write that cycle,
    // otherwise a stale write could re-open nesting inside the handler.
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            global_en <= 1'b0;
        end else if (take_ok) begin
            global_en <= 1'b0;
        end else if (irq_return) begin
            global_en <= 1'b1;
        end else if (reg_wr && ctrl_sel) begin
            global_en <= reg_wdata[`PIEB_BIT_GLOBAL];
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            periph_en <= 1'b0;
        end else if (reg_wr && ctrl_sel) begin
            periph_en <= reg_wdata[`PIEB_BIT_PERIPH];
        end
    end

    always_comb begin
        case (vec_state)
            VS_IDLE: next_vec_state = take_ok ? VS_LOAD : VS_IDLE;
            VS_LOAD: next_vec_state = take_ok ? VS_LOAD : VS_IDLE;
            default: next_vec_state = VS_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            vec_state <= VS_IDLE;
        end else begin
            vec_state <= next_vec_state;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            vector_addr <= `PIEB_RST_VEC;
        end else if (take_ok) begin
            vector_addr <= `PIEB_VECTOR;
        end
    end

    assign vector_load = (vec_state == VS_LOAD);

    // Checks on the enable bank, the gating and the vector request.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_n);

    sequence s_wr_en1;
        reg_wr && reg_addr == `PIEB_OFS_EN1;
    endsequence

    sequence s_take;
        irq_take && irq && global_en;
    endsequence

    sequence s_vectored;
        vector_load && vector_addr == `PIEB_VECTOR && !global_en;
    endsequence

    property p_en1_store;
        s_wr_en1 |=> en_q[0] == $past(reg_wdata);
    endproperty
    a_en1_store: assert property (p_en1_store)
        else $error("Group 1 enable did not store the written byte.");

    property p_en1_read;
        s_wr_en1 ##1 (reg_rd && reg_addr == `PIEB_OFS_EN1 && !reg_wr)
            |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_en1_read: assert property (p_en1_read)
        else $error("Group 1 enable read back differs from write.");

    property p_en2_absent;
        en_q[1][7] == 1'b0 && en_q[1][4] == 1'b0;
    endproperty
    a_en2_absent: assert property (p_en2_absent)
        else $error("Absent bits of group 2 became set.");

    property p_en2_store;
        reg_wr && reg_addr == `PIEB_OFS_EN2
            |=> en_q[1] == ($past(reg_wdata) & `PIEB_IMPL_G2);
    endproperty
    a_en2_store: assert property (p_en2_store)
        else $error("Group 2 enable did not store its implemented bits.");

    property p_en3_absent;
        reg_rd && reg_addr == `PIEB_OFS_EN3
            |=> reg_rdata[7:4] == 4'h0;
    endproperty
    a_en3_absent: assert property (p_en3_absent)
        else $error("Group 3 upper nibble did not read as zero.");

    property p_en3_store;
        reg_wr && reg_addr == `PIEB_OFS_EN3
            |=> en_q[2] == ($past(reg_wdata) & `PIEB_IMPL_G3);
    endproperty
    a_en3_store: assert property (p_en3_store)
        else $error("Group 3 enable did not store its low nibble.");

    property p_en4_hold;
        reg_wr && reg_addr == `PIEB_OFS_EN4
            ##1 !(reg_wr && reg_addr == `PIEB_OFS_EN4) [*3]
            |-> en_q[3] == $past(reg_wdata, 3);
    endproperty
    a_en4_hold: assert property (p_en4_hold)
        else $error("Group 4 enable lost its value without a write.");

    property p_en4_store;
        reg_wr && reg_addr == `PIEB_OFS_EN4 |=> $stable(en_q[4])
            && en_q[3] == $past(reg_wdata);
    endproperty
    a_en4_store: assert property (p_en4_store)
        else $error("Write to group 4 stored wrongly or touched group 5.");

    property p_en5_store;
        reg_wr && reg_addr == `PIEB_OFS_EN5 |=> en_q[4] == $past(reg_wdata);
    endproperty
    a_en5_store: assert property (p_en5_store)
        else $error("Group 5 enable did not store the written byte.");

    property p_en5_read;
        reg_rd && reg_addr == `PIEB_OFS_EN5 |=> reg_rdata == $past(en_q[4]);
    endproperty
    a_en5_read: assert property (p_en5_read)
        else $error("Group 5 enable read data differs from the register.");

    property p_blocked;
        (flag_flat & en_flat) == '0 |-> !periph_irq_req && !irq;
    endproperty
    a_blocked: assert property (p_blocked)
        else $error("Request raised with no flagged enabled source.");

    property p_masters;
        irq |-> global_en && periph_en && periph_irq_req;
    endproperty
    a_masters: assert property (p_masters)
        else $error("Interrupt raised without both master enables.");

    property p_flag_set;
        (src_event & impl_flat) != '0 |=>
            (flag_flat & $past(src_event & impl_flat))
                == $past(src_event & impl_flat);
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("Source event did not set its flag.");

    property p_vector;
        s_take |=> s_vectored;
    endproperty
    a_vector: assert property (p_vector)
        else $error("Taken interrupt did not vector to 0004h.");

    property p_no_vector;
        !$past(take_ok) |-> !vector_load;
    endproperty
    a_no_vector: assert property (p_no_vector)
        else $error("Vector load without a taken interrupt.");

    property p_req_or;
        periph_irq_req == |(flag_flat & en_flat);
    endproperty
    a_req_or: assert property (p_req_or)
        else $error("Peripheral request differs from OR of flag and enable.");

    property p_rd_one_cycle;
        !reg_rd |=> reg_rdata == `PIEB_ZERO_BYTE;
    endproperty
    a_rd_one_cycle: assert property (p_rd_one_cycle)
        else $error("Read data stood outside the cycle after a read.");

    property p_ret_sets;
        irq_return && !take_ok |=> global_en;
    endproperty
    a_ret_sets: assert property (p_ret_sets)
        else $error("Return from handler did not set the global enable.");

endmodule : pieb_bank

// File: verification/pieb_core_model.sv
// Behavioural model of the processor core that takes and returns interrupts.
`timescale 1ns/1ps

module pieb_core_model (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       irq,
    input  wire logic       take_en,
    input  wire logic [3:0] take_delay,
    input  wire logic       force_take,
    input  wire logic       ret_req,
    output logic            irq_take,
    output logic            irq_return
);
    logic [3:0] wait_cnt;

    // A slow core lets irq stand for take_delay + 1 cycles before it answers.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irq_take   <= 1'b0;
            irq_return <= 1'b0;
            wait_cnt   <= 4'h0;
        end else begin
            irq_take   <= force_take;
            irq_return <= ret_req;
            if (take_en && irq && !irq_take) begin
                if (wait_cnt >= take_delay) begin
                    irq_take <= 1'b1;
                    wait_cnt <= 4'h0;
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end else begin
                wait_cnt <= 4'h0;
            end
        end
    end
endmodule : pieb_core_model

// File: verification/tb_top.sv
// Self-checking testbench of the peripheral interrupt enable bank.
`timescale 1ns/1ps
`include "pieb_map.svh"

module tb_top;
    import pieb_pkg::*;
    logic        core_clk, rstn, reg_wr, reg_rd, irq_take, irq_return;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [39:0] src_event;
    logic        periph_irq_req, irq, vector_load, take_en, force_take;
    logic        ret_req;
    logic [3:0]  take_delay;
    logic [15:0] vector_addr;
    pieb_byte_t  en_m[5], fl_m[5], ctrl_m, d;
    int          err_total, samples_checked, vl_cnt, seed;
    int unsigned r, g, k;

    pieb_bank i_pieb_bank (.core_clk(core_clk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event(src_event),
        .irq_take(irq_take), .irq_return(irq_return),
        .periph_irq_req(periph_irq_req), .irq(irq),
        .vector_load(vector_load), .vector_addr(vector_addr));

    pieb_core_model i_pieb_core_model (.core_clk(core_clk), .rstn(rstn),
        .irq(irq), .take_en(take_en), .take_delay(take_delay),
        .force_take(force_take), .ret_req(ret_req),
        .irq_take(irq_take), .irq_return(irq_return));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Sampled mid-cycle so the count never races the flop update.
    always @(negedge core_clk) begin
        if (vector_load === 1'b1) vl_cnt++;
    end

    function automatic pieb_byte_t impl_of(input int unsigned grp);
        case (grp)
            1: impl_of = `PIEB_IMPL_G2;
            2: impl_of = `PIEB_IMPL_G3;
            default: impl_of = 8'hFF;
        endcase
    endfunction : impl_of

    function automatic logic exp_req();
        exp_req = 1'b0;
        for (int i = 0; i < 5; i++) exp_req |= |(fl_m[i] & en_m[i]);
    endfunction : exp_req

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic bus_wr(input pieb_byte_t a, input pieb_byte_t v);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input pieb_byte_t a, input pieb_byte_t exp);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk_word({8'h00, reg_rdata}, {8'h00, exp});
    endtask : bus_rd

    task automatic pulse_evt(input int unsigned idx);
        @(posedge core_clk);
        src_event <= 40'h1 << idx;
        @(posedge core_clk);
        src_event <= 40'h0;
        #1;
    endtask : pulse_evt

    task automatic wait_vec();
        for (int i = 0; i < 20 && vector_load !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
    endtask : wait_vec

    task automatic tally_and_finish();
        $display("Checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #(25 * 40000);
        err_total++;
        tally_and_finish();
    end

    initial begin
        {rstn, reg_wr, reg_rd, take_en, force_take, ret_req} = 6'h00;
        {reg_addr, reg_wdata, take_delay} = 20'h00000;
        src_event = 40'h0;
        err_total = 0;
        samples_checked = 0;
        vl_cnt = 0;
        seed = 17;
        ctrl_m = 8'h00;
        for (int i = 0; i < 5; i++) {en_m[i], fl_m[i]} = 16'h0000;
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        chk_bit(irq, 1'b0);
        for (g = 0; g < 5; g++) begin
            bus_rd(`PIEB_OFS_EN1 + g[7:0], 8'h00);
            bus_wr(`PIEB_OFS_EN1 + g[7:0], 8'hFF);
            bus_rd(`PIEB_OFS_EN1 + g[7:0], impl_of(g));
            bus_wr(`PIEB_OFS_EN1 + g[7:0], 8'h00);
        end
        // A read right behind a write must already see the new byte.
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= `PIEB_OFS_EN1;
        reg_wdata <= 8'h5A;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk_word({8'h00, reg_rdata}, 16'h005A);
        bus_wr(`PIEB_OFS_EN1, 8'h00);
        // An event and its clear in one cycle leave the flag set.
        @(posedge core_clk);
        src_event <= 40'h1;
        reg_wr    <= 1'b1;
        reg_addr  <= `PIEB_OFS_FLAG1;
        reg_wdata <= 8'h01;
        @(posedge core_clk);
        src_event <= 40'h0;
        reg_wr    <= 1'b0;
        bus_rd(`PIEB_OFS_FLAG1, 8'h01);
        bus_wr(`PIEB_OFS_FLAG1, 8'h01);
        bus_rd(`PIEB_OFS_FLAG1, 8'h00);
        // Neighbours of the bank must neither answer nor alias into it.
        bus_wr(8'h96, 8'hFF);
        bus_wr(8'h9C, 8'hFF);
        bus_rd(8'h9C, 8'h00);
        bus_rd(`PIEB_OFS_EN1, 8'h00);
        bus_rd(`PIEB_OFS_EN5, 8'h00);
        repeat (400) begin
            r = $random(seed);
            g = r % 5;
            d = 8'($random(seed));
            case (r[9:8])
                2'h0: begin
                    bus_wr(`PIEB_OFS_EN1 + g[7:0], d);
                    en_m[g] = d & impl_of(g);
                end
                2'h1: begin
                    pulse_evt(g * 8 + d[2:0]);
                    fl_m[g] |= (8'h01 << d[2:0]) & impl_of(g);
                end
                2'h2: begin
                    bus_wr(`PIEB_OFS_FLAG1 + g[7:0], d);
                    fl_m[g] &= ~d;
                end
                default: begin
                    bus_wr(`PIEB_OFS_CTRL, d);
                    ctrl_m = d & 8'hC0;
                end
            endcase
            bus_rd(`PIEB_OFS_EN1 + g[7:0], en_m[g]);
            bus_rd(`PIEB_OFS_FLAG1 + g[7:0], fl_m[g]);
            chk_bit(periph_irq_req, exp_req());
            chk_bit(irq, exp_req() & ctrl_m[7] & ctrl_m[6]);
        end
        bus_wr(`PIEB_OFS_CTRL, 8'h00);
        for (g = 0; g < 5; g++) begin
            bus_wr(`PIEB_OFS_FLAG1 + g[7:0], 8'hFF);
            bus_wr(`PIEB_OFS_EN1 + g[7:0], 8'h00);
        end
        bus_wr(`PIEB_OFS_EN1, 8'h40);
        pulse_evt(6);
        bus_wr(`PIEB_OFS_CTRL, 8'hC0);
        #1;
        chk_bit(irq, 1'b1);
        k = vl_cnt;
        take_delay <= 4'h2;
        take_en    <= 1'b1;
        wait_vec();
        take_en <= 1'b0;
        chk_bit(vector_load, 1'b1);
        chk_word(vector_addr, `PIEB_VECTOR);
        chk_bit(irq, 1'b0);
        bus_rd(`PIEB_OFS_CTRL, 8'h40);
        // A take while irq is low must not vector again.
        @(posedge core_clk);
        force_take <= 1'b1;
        @(posedge core_clk);
        force_take <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        chk_word(16'(vl_cnt), 16'(k + 1));
        @(posedge core_clk);
        ret_req <= 1'b1;
        @(posedge core_clk);
        ret_req <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk_bit(irq, 1'b1);
        take_delay <= 4'h0;
        take_en    <= 1'b1;
        wait_vec();
        take_en <= 1'b0;
        chk_bit(vector_load, 1'b1);
        bus_wr(`PIEB_OFS_FLAG1, 8'h40);
        #1;
        chk_bit(periph_irq_req, 1'b0);
        chk_word(16'(vl_cnt), 16'(k + 2));
        tally_and_finish();
    end
endmodule : tb_top
